/* inc/slt_regs.svh */
// Purpose: Register offsets, bit positions, reset values and timing counts of the serial line core.
// Assumes: Each 16-bit register sits in the low half of one aligned 32-bit word.
// Notes: Offsets are byte addresses on the register bus.
// How it works
// - Bits 15-12 select the serial bit rate.
// - Rate code loads only with bit 11 set.
// - Ready flag shows holding buffer free; init sets.
// - Ready rising with enable raises transmit request.
// - Maintenance loops transmit output into receiver.
// - Break bit holds the line at space.
// - Reserved and write-only control bits read zero.
// - Writes leave read-only and unused bits alone.
// - Holding buffer upper byte is undefined.
// - Holding buffer character bits are write-only.
// - Init signal applies every initialization effect.
// - Receiver and transmitter requests are kept separately.
// - Receiver request goes out before transmitter request.
// - Receiver done rising with enable raises request.
// - Done sets only after a whole character.
// - Modem change rising with enable raises request.
// - Any modem status change sets change flag.
// - Ready drops briefly when first character loads.
// - Done sets at middle of first stop.
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH
`define SLT_TCS_OFS 5'h00
`define SLT_THB_OFS 5'h04
`define SLT_RCS_OFS 5'h08
`define SLT_RBF_OFS 5'h0C
`define SLT_TCS_RATE_EN 11
`define SLT_TCS_TXIE 6
`define SLT_TCS_MAINT 2
`define SLT_TCS_BRK 0
`define SLT_RCS_MCHG 15
`define SLT_RCS_RXIE 6
`define SLT_RCS_MDIE 5
`define SLT_RATE_RST 4'hE
`define SLT_CLK_HZ 40000000
`define SLT_OVS 16
`endif

/* inc/slt_pkg.sv */
// Purpose: Types shared by the serial line core.
// Assumes: Included after the register header.
// Notes: State codes are left to the tools.
`include "slt_regs.svh"
package slt_pkg;
  typedef enum logic {TX_IDLE, TX_SEND} slt_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} slt_rx_st_t;
endpackage

/* core/slt_core.sv */
// Purpose: Serial line transmitter control, holding buffer, receiver and interrupt requests.
// Assumes: INIT comes from logic on CORE_CLK; serial and modem pins are asynchronous.
// Notes: Registers are reached over Avalon-MM; every access waits exactly one cycle.
`timescale 1ns/1ps
`include "slt_regs.svh"
module slt_core
  import slt_pkg::*;
#(
  parameter int DATA_BITS  = 8,
  parameter int PARITY_EN  = 0,
  parameter int PARITY_ODD = 0,
  parameter int STOP_BITS  = 1
)(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        INIT,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        RXD,
  input  wire logic        CARRIER_PRESENT,
  input  wire logic        PEER_READY_TO_RECEIVE,
  input  wire logic        SECONDARY_RECEIVE_LINE,
  input  wire logic        RING_INDICATOR,
  input  wire logic        IRQ_ACK,
  output logic             TXD,
  output logic             RX_IRQ,
  output logic             TX_IRQ
);
  localparam int FW = 1 + DATA_BITS + PARITY_EN + STOP_BITS;
  localparam int RW = DATA_BITS + PARITY_EN;
  localparam logic [3:0] PH_FULL = 4'(`SLT_OVS - 1);
  localparam logic [3:0] PH_HALF = 4'(`SLT_OVS / 2 - 1);

  logic [4:0]    sync1;
  logic [4:0]    sync2;
  logic [4:0]    sync3;
  logic [15:0]   pre;
  logic [15:0]   next_pre;
  logic          tick;
  logic [3:0]    rate_code;
  logic [3:0]    next_rate;
  logic          tx_ie, next_tx_ie, maint, next_maint, brk, next_brk;
  logic [7:0]    hold_data, next_hold_data, rx_data, next_rx_data;
  logic          hold_full, next_hold_full, can_accept;
  logic          rx_ie, next_rx_ie, mdm_ie, next_mdm_ie, mdm_chg, next_mdm_chg;
  logic          rx_done, next_rx_done, ovr, next_ovr, frm, next_frm, par, next_par;
  logic          next_waitreq, wr, rd_rbf, chg, perr;
  logic [31:0]   next_rdata;
  slt_tx_st_t    tx_st, next_tx_st;
  logic [FW-1:0] tx_sh, next_tx_sh, frame;
  logic [3:0]    tx_bits, next_tx_bits, tx_ph, next_tx_ph;
  logic          tx_line, next_tx_line, next_txd, tx_take;
  slt_rx_st_t    rx_st, next_rx_st;
  logic [RW-1:0] rx_sh, next_rx_sh;
  logic [3:0]    rx_n, next_rx_n, rx_ph, next_rx_ph;
  logic          rx_in, rx_evt, next_rx_evt, rx_frm, next_rx_frm;
  logic          tx_req, next_tx_req, rxd_req, next_rxd_req, mdm_req, next_mdm_req;
  logic [2:0]    cond_q, next_cond_q;
  logic          cond_tx, cond_rx, cond_md, ack_rx, ack_tx, next_rx_irq, next_tx_irq;

  // Returns one less than the core clock count per oversampling tick for a rate code.
  function automatic logic [15:0] rate_div(input logic [3:0] code);
    int baud;
    baud = 9600;
    unique case (code)
      4'h0: baud = 50;
      4'h1: baud = 75;
      4'h2: baud = 110;
      4'h3: baud = 134;
      4'h4: baud = 150;
      4'h5: baud = 300;
      4'h6: baud = 600;
      4'h7: baud = 1200;
      4'h8: baud = 1800;
      4'h9: baud = 2000;
      4'hA: baud = 2400;
      4'hB: baud = 3600;
      4'hC: baud = 4800;
      4'hD: baud = 7200;
      4'hE: baud = 9600;
      4'hF: baud = 9600;
    endcase
    return 16'(`SLT_CLK_HZ / (`SLT_OVS * baud) - 1);
  endfunction

  // Two flip-flops on every pin input; a third stage only feeds change detection.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1 <= 5'h01;
      sync2 <= 5'h01;
      sync3 <= 5'h01;
    end else begin
      sync1 <= {RING_INDICATOR, SECONDARY_RECEIVE_LINE, PEER_READY_TO_RECEIVE, CARRIER_PRESENT, RXD};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Divider that makes one oversampling tick per sixteenth of a bit period at the selected rate.
  always_comb begin
    tick     = (pre == 16'h0000);
    next_pre = tick ? rate_div(rate_code) : 16'(pre - 16'h0001);
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pre <= 16'h0000;
    end else begin
      pre <= next_pre;
    end
  end

  // Bus slave and register file: answer one cycle after the request, side effects at the accepting edge.
  always_comb begin
    can_accept     = ~hold_full;
    wr             = AVS_WRITE & ~AVS_WAITREQUEST;
    rd_rbf         = AVS_READ & ~AVS_WAITREQUEST & (AVS_ADDRESS == `SLT_RBF_OFS);
    chg            = |(sync2[4:1] ^ sync3[4:1]);
    perr           = (PARITY_EN != 0) && ((^rx_sh) != (PARITY_ODD != 0));
    next_waitreq   = ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    next_rdata     = 32'h0000_0000;
    next_rate      = rate_code;
    next_tx_ie     = tx_ie;
    next_maint     = maint;
    next_brk       = brk;
    next_hold_data = hold_data;
    next_hold_full = hold_full;
    next_rx_ie     = rx_ie;
    next_mdm_ie    = mdm_ie;
    next_mdm_chg   = mdm_chg;
    next_rx_done   = rx_done;
    next_rx_data   = rx_data;
    next_ovr       = ovr;
    next_frm       = frm;
    next_par       = par;
    if (AVS_READ && AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        `SLT_TCS_OFS: next_rdata = 32'({8'h00, can_accept, tx_ie, 3'h0, maint, 1'h0, brk});
        `SLT_THB_OFS: next_rdata = 32'h0000_0000;
        `SLT_RCS_OFS: next_rdata = 32'({mdm_chg, sync2[4:1], 3'h0, rx_done, rx_ie, mdm_ie, 5'h00});
        `SLT_RBF_OFS: next_rdata = 32'({ovr | frm | par, ovr, frm, par, 4'h0, rx_data});
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr && AVS_ADDRESS == `SLT_TCS_OFS) begin
      if (AVS_BYTEENABLE[1] && AVS_WRITEDATA[`SLT_TCS_RATE_EN]) begin
        next_rate = AVS_WRITEDATA[15:12];
      end
      if (AVS_BYTEENABLE[0]) begin
        next_tx_ie = AVS_WRITEDATA[`SLT_TCS_TXIE];
        next_maint = AVS_WRITEDATA[`SLT_TCS_MAINT];
        next_brk   = AVS_WRITEDATA[`SLT_TCS_BRK];
      end
    end
    if (wr && AVS_ADDRESS == `SLT_RCS_OFS) begin
      if (AVS_BYTEENABLE[0]) begin
        next_rx_ie  = AVS_WRITEDATA[`SLT_RCS_RXIE];
        next_mdm_ie = AVS_WRITEDATA[`SLT_RCS_MDIE];
      end
      if (AVS_BYTEENABLE[1] && AVS_WRITEDATA[`SLT_RCS_MCHG]) begin
        next_mdm_chg = 1'h0;
      end
    end
    if (rd_rbf) begin
      next_rx_done = 1'h0;
    end
    // Hardware sets come after the software clears so that a coincident event wins.
    if (tx_take) begin
      next_hold_full = 1'h0;
    end
    if (wr && AVS_ADDRESS == `SLT_THB_OFS && AVS_BYTEENABLE[0]) begin
      next_hold_data = 8'(AVS_WRITEDATA[DATA_BITS-1:0]);
      next_hold_full = 1'h1;
    end
    if (chg) begin
      next_mdm_chg = 1'h1;
    end
    if (rx_evt) begin
      next_ovr     = next_rx_done;
      next_rx_done = 1'h1;
      next_rx_data = 8'(rx_sh[DATA_BITS-1:0]);
      next_frm     = rx_frm;
      next_par     = perr;
    end
    if (INIT) begin
      next_tx_ie     = 1'h0;
      next_maint     = 1'h0;
      next_brk       = 1'h0;
      next_hold_full = 1'h0;
      next_rx_ie     = 1'h0;
      next_mdm_ie    = 1'h0;
      next_mdm_chg   = 1'h0;
      next_rx_done   = 1'h0;
      next_ovr       = 1'h0;
      next_frm       = 1'h0;
      next_par       = 1'h0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'h1;
      AVS_READDATA    <= 32'h0000_0000;
      rate_code       <= `SLT_RATE_RST;
      tx_ie           <= 1'h0;
      maint           <= 1'h0;
      brk             <= 1'h0;
      hold_data       <= 8'h00;
      hold_full       <= 1'h0;
      rx_ie           <= 1'h0;
      mdm_ie          <= 1'h0;
      mdm_chg         <= 1'h0;
      rx_done         <= 1'h0;
      rx_data         <= 8'h00;
      ovr             <= 1'h0;
      frm             <= 1'h0;
      par             <= 1'h0;
    end else begin
      AVS_WAITREQUEST <= next_waitreq;
      AVS_READDATA    <= next_rdata;
      rate_code       <= next_rate;
      tx_ie           <= next_tx_ie;
      maint           <= next_maint;
      brk             <= next_brk;
      hold_data       <= next_hold_data;
      hold_full       <= next_hold_full;
      rx_ie           <= next_rx_ie;
      mdm_ie          <= next_mdm_ie;
      mdm_chg         <= next_mdm_chg;
      rx_done         <= next_rx_done;
      rx_data         <= next_rx_data;
      ovr             <= next_ovr;
      frm             <= next_frm;
      par             <= next_par;
    end
  end

  // Transmit shifter: takes the holding buffer on a tick and sends one frame bit per sixteen ticks.
  always_comb begin
    frame = '1;
    frame[0] = 1'h0;
    frame[DATA_BITS:1] = hold_data[DATA_BITS-1:0];
    if (PARITY_EN != 0) begin
      frame[DATA_BITS+1] = (^hold_data[DATA_BITS-1:0]) ^ (PARITY_ODD != 0);
    end
    tx_take      = 1'h0;
    next_tx_st   = tx_st;
    next_tx_sh   = tx_sh;
    next_tx_bits = tx_bits;
    next_tx_ph   = tx_ph;
    next_tx_line = tx_line;
    unique case (tx_st)
      TX_IDLE: begin
        if (tick && hold_full) begin
          tx_take      = 1'h1;
          next_tx_st   = TX_SEND;
          next_tx_sh   = frame;
          next_tx_bits = 4'(FW);
          next_tx_ph   = PH_FULL;
          next_tx_line = 1'h0;
        end
      end
      TX_SEND: begin
        if (tick) begin
          if (tx_ph != 4'h0) begin
            next_tx_ph = 4'(tx_ph - 4'h1);
          end else if (tx_bits == 4'h1) begin
            next_tx_st   = TX_IDLE;
            next_tx_line = 1'h1;
          end else begin
            next_tx_sh   = {1'h1, tx_sh[FW-1:1]};
            next_tx_line = tx_sh[1];
            next_tx_bits = 4'(tx_bits - 4'h1);
            next_tx_ph   = PH_FULL;
          end
        end
      end
    endcase
    if (INIT) begin
      tx_take      = 1'h0;
      next_tx_st   = TX_IDLE;
      next_tx_line = 1'h1;
    end
    next_txd = ~brk & next_tx_line;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_st   <= TX_IDLE;
      tx_sh   <= '1;
      tx_bits <= 4'h0;
      tx_ph   <= 4'h0;
      tx_line <= 1'h1;
      TXD     <= 1'h1;
    end else begin
      tx_st   <= next_tx_st;
      tx_sh   <= next_tx_sh;
      tx_bits <= next_tx_bits;
      tx_ph   <= next_tx_ph;
      tx_line <= next_tx_line;
      TXD     <= next_txd;
    end
  end

  // Receiver: finds the start edge, samples each bit at its middle and signals at mid stop.
  always_comb begin
    rx_in       = maint ? TXD : sync2[0];
    next_rx_st  = rx_st;
    next_rx_sh  = rx_sh;
    next_rx_n   = rx_n;
    next_rx_ph  = rx_ph;
    next_rx_frm = rx_frm;
    next_rx_evt = 1'h0;
    if (tick) begin
      unique case (rx_st)
        RX_IDLE: begin
          if (!rx_in) begin
            next_rx_st = RX_START;
            next_rx_ph = PH_HALF;
          end
        end
        RX_START: begin
          if (rx_ph != 4'h0) begin
            next_rx_ph = 4'(rx_ph - 4'h1);
          end else if (rx_in) begin
            next_rx_st = RX_IDLE;
          end else begin
            next_rx_st = RX_DATA;
            next_rx_ph = PH_FULL;
            next_rx_n  = 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_ph != 4'h0) begin
            next_rx_ph = 4'(rx_ph - 4'h1);
          end else begin
            next_rx_sh = {rx_in, rx_sh[RW-1:1]};
            next_rx_n  = 4'(rx_n + 4'h1);
            next_rx_ph = PH_FULL;
            if (rx_n == 4'(RW - 1)) begin
              next_rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_ph != 4'h0) begin
            next_rx_ph = 4'(rx_ph - 4'h1);
          end else begin
            next_rx_evt = 1'h1;
            next_rx_frm = ~rx_in;
            next_rx_st  = RX_IDLE;
          end
        end
      endcase
    end
    if (INIT) begin
      next_rx_st  = RX_IDLE;
      next_rx_evt = 1'h0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_st  <= RX_IDLE;
      rx_sh  <= '0;
      rx_n   <= 4'h0;
      rx_ph  <= 4'h0;
      rx_frm <= 1'h0;
      rx_evt <= 1'h0;
    end else begin
      rx_st  <= next_rx_st;
      rx_sh  <= next_rx_sh;
      rx_n   <= next_rx_n;
      rx_ph  <= next_rx_ph;
      rx_frm <= next_rx_frm;
      rx_evt <= next_rx_evt;
    end
  end

  // Interrupt channels: each request starts on a rising cause and ends on a lost cause or on acknowledge, the modem one only with no receiver request pending.
  always_comb begin
    cond_tx      = can_accept & tx_ie;
    cond_rx      = rx_done & rx_ie;
    cond_md      = mdm_chg & mdm_ie;
    ack_rx       = IRQ_ACK & RX_IRQ;
    ack_tx       = IRQ_ACK & TX_IRQ;
    next_tx_req  = cond_tx & (tx_req | ~cond_q[0]) & ~ack_tx;
    next_rxd_req = cond_rx & (rxd_req | ~cond_q[1]) & ~ack_rx;
    next_mdm_req = cond_md & (mdm_req | ~cond_q[2]) & ~(ack_rx & ~rxd_req);
    if (INIT) begin
      next_tx_req  = 1'h0;
      next_rxd_req = 1'h0;
      next_mdm_req = 1'h0;
    end
    next_cond_q = {cond_md, cond_rx, cond_tx};
    next_rx_irq = next_rxd_req | next_mdm_req;
    next_tx_irq = next_tx_req & ~next_rx_irq;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_req  <= 1'h0;
      rxd_req <= 1'h0;
      mdm_req <= 1'h0;
      cond_q  <= 3'h0;
      RX_IRQ  <= 1'h0;
      TX_IRQ  <= 1'h0;
    end else begin
      tx_req  <= next_tx_req;
      rxd_req <= next_rxd_req;
      mdm_req <= next_mdm_req;
      cond_q  <= next_cond_q;
      RX_IRQ  <= next_rx_irq;
      TX_IRQ  <= next_tx_irq;
    end
  end

  // Checks on the core's own outputs and state.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_rate_load;
    wr && AVS_ADDRESS == `SLT_TCS_OFS && AVS_BYTEENABLE[1] && AVS_WRITEDATA[11] |=> rate_code == $past(AVS_WRITEDATA[15:12]);
  endproperty
  a_rate_load: assert property (p_rate_load) else $error("Rate code not loaded.");
  property p_rate_keep;
    wr && AVS_ADDRESS == `SLT_TCS_OFS && !AVS_WRITEDATA[11] |=> $stable(rate_code);
  endproperty
  a_rate_keep: assert property (p_rate_keep) else $error("Rate code changed without enable.");
  property p_init_ready;
    INIT |=> can_accept && !tx_ie && !maint && !brk ##1 TXD;
  endproperty
  a_init_ready: assert property (p_init_ready) else $error("Init effects missing.");
  property p_tx_irq;
    cond_tx && !cond_q[0] && !INIT && !next_rx_irq |=> tx_req ##1 TX_IRQ || RX_IRQ || !tx_req;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("Transmit request not raised.");
  property p_break;
    brk |=> !TXD;
  endproperty
  a_break: assert property (p_break) else $error("Break not at space.");
  property p_rsv;
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == `SLT_TCS_OFS |=> AVS_READDATA[15:8] == 8'h00 && AVS_READDATA[5:3] == 3'h0 && !AVS_READDATA[1];
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved bit read nonzero.");
  property p_prio;
    RX_IRQ |-> !TX_IRQ;
  endproperty
  a_prio: assert property (p_prio) else $error("Transmit request beside receiver request.");
  property p_rx_irq;
    cond_rx && !cond_q[1] && !INIT |=> rxd_req ##1 RX_IRQ || !rxd_req;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("Receiver request not raised.");
  property p_done_mid;
    rx_evt |-> $past(rx_st, 2) == RX_STOP && rx_st == RX_IDLE;
  endproperty
  a_done_mid: assert property (p_done_mid) else $error("Done outside stop bit.");
  property p_mdm;
    chg && !INIT |=> mdm_chg;
  endproperty
  a_mdm: assert property (p_mdm) else $error("Modem change lost.");
  property p_req_hold;
    tx_req && cond_tx && !ack_tx && !INIT |=> tx_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("Request dropped early.");
  property p_ready_back;
    tx_take && !(wr && AVS_ADDRESS == `SLT_THB_OFS) |=> can_accept;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("Ready not back after take.");
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("Bus answer late.");

  c_break: cover property (brk ##1 !TXD);
  c_loop: cover property (maint && rx_evt);
  c_tx_irq: cover property (TX_IRQ ##1 IRQ_ACK);
  c_mdm_irq: cover property (mdm_req && RX_IRQ);
endmodule

/* bench/slt_far_end.sv */
// Purpose: Far-end terminal model that decodes the characters sent on the serial output.
// Assumes: Eight data bits, no parity, one stop bit, a bit length given in clock cycles.
// Notes: Its own line rests at mark and sits at space while it decodes a frame; a short start is dropped.
`timescale 1ns/1ps
module slt_far_end #(
  parameter int BIT_CYC = 4160
)(
  input  wire logic       clk,
  input  wire logic       txd,
  output logic            rxd,
  output logic [7:0]      got,
  output int              got_n
);
  // Idle terminal holds its line at mark and assembles each frame least significant bit first.
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_n = 0;
    forever begin
      @(posedge clk);
      if (txd === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge clk);
        if (txd === 1'b0) begin
          rxd <= 1'b0;
          for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            got[i] = txd;
          end
          repeat (BIT_CYC) @(posedge clk);
          got_n = got_n + 1;
          rxd <= 1'b1;
        end
      end
    end
  end
endmodule

/* bench/tb.sv */
// Purpose: Self-checking bench for the serial line core registers, serial output and requests.
// Assumes: Rate code 0xF gives 260 cycles per tick and 16 ticks, 4160 cycles, per bit.
// Notes: All register traffic goes through one bus task; a cycle ceiling cuts a hang short.
`timescale 1ns/1ps
module tb;
  logic        core_clk        = 1'b0;
  logic        sys_rst         = 1'b1;
  logic        init            = 1'b0;
  logic        rd              = 1'b0;
  logic        wr              = 1'b0;
  logic [4:0]  addr            = 5'h00;
  logic [31:0] wdata           = 32'h00000000;
  logic        carrier         = 1'b0;
  logic        ack             = 1'b0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        txd;
  logic        rxd;
  logic        rx_irq;
  logic        tx_irq;
  logic [7:0]  got;
  logic [15:0] q;
  int          got_n;
  int          err_total       = 0;
  int          samples_checked = 0;
  int          cycles          = 0;

  // Free-running core clock at 40 MHz.
  always #12.5 core_clk = ~core_clk;

  slt_core i_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .INIT(init), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .RXD(rxd), .CARRIER_PRESENT(carrier), .PEER_READY_TO_RECEIVE(1'b0),
    .SECONDARY_RECEIVE_LINE(1'b0), .RING_INDICATOR(1'b0), .IRQ_ACK(ack), .TXD(txd), .RX_IRQ(rx_irq),
    .TX_IRQ(tx_irq));

  slt_far_end #(.BIT_CYC(4160)) i_far (.clk(core_clk), .txd(txd), .rxd(rxd), .got(got), .got_n(got_n));

  task automatic conclude();
    $display("Mismatches %0d in %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  // One bus access: request held until waitrequest is sampled low, then released.
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= {16'h0000, d};
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge core_clk);
    end while (waitreq !== 1'b0);
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
    chk({15'h0000, waitreq}, 16'h0000);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask

  task automatic wait_irq(input logic rx, input int lim);
    int n;
    n = 0;
    while ((rx ? rx_irq : tx_irq) !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk({15'h0000, rx ? rx_irq : tx_irq}, 16'h0001);
  endtask

  task automatic pulse_ack();
    @(posedge core_clk);
    ack <= 1'b1;
    @(posedge core_clk);
    ack <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Cycle ceiling well above the single character plus register traffic.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      err_total++;
      conclude();
    end
  end

  // Main sequence of register, serial and request scenarios.
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(5'h00, 16'h0080);
    rd_chk(5'h04, 16'h0000);
    rd_chk(5'h10, 16'h0000);
    chk({15'h0000, txd}, 16'h0001);
    bus(1'b1, 5'h00, 16'hFFFF);
    rd_chk(5'h00, 16'h00C5);
    wait_irq(1'b0, 4);
    chk({15'h0000, txd}, 16'h0000);
    pulse_ack();
    chk({15'h0000, tx_irq}, 16'h0000);
    bus(1'b1, 5'h00, 16'h0044);
    repeat (2) @(posedge core_clk);
    chk({15'h0000, txd}, 16'h0001);
    bus(1'b1, 5'h08, 16'h0060);
    // Let any false start left by the short break die out before sending.
    repeat (2200) @(posedge core_clk);
    bus(1'b1, 5'h04, 16'h00A5);
    wait_irq(1'b0, 4200);
    rd_chk(5'h00, 16'h00C4);
    wait_irq(1'b1, 42000);
    repeat (2) @(posedge core_clk);
    chk({15'h0000, tx_irq}, 16'h0000);
    rd_chk(5'h0C, 16'h00A5);
    repeat (3) @(posedge core_clk);
    chk({14'h0000, rx_irq, tx_irq}, 16'h0001);
    chk({8'h00, got}, 16'h00A5);
    chk(16'(got_n), 16'h0001);
    // A carrier change raises the modem request and shows in the receiver status.
    carrier <= 1'b1;
    wait_irq(1'b1, 10);
    rd_chk(5'h08, 16'h8860);
    bus(1'b1, 5'h08, 16'h8060);
    repeat (2) @(posedge core_clk);
    chk({14'h0000, rx_irq, tx_irq}, 16'h0001);
    // No acknowledge is offered while the enable is cleared, as if the host sat at top priority.
    bus(1'b1, 5'h00, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk({15'h0000, tx_irq}, 16'h0000);
    @(posedge core_clk);
    init <= 1'b1;
    @(posedge core_clk);
    init <= 1'b0;
    rd_chk(5'h00, 16'h0080);
    rd_chk(5'h08, 16'h0800);
    chk({14'h0000, rx_irq, tx_irq}, 16'h0000);
    conclude();
  end
endmodule
